// ---- hw/tsmi_top.sv ----
// Transmit 257-bit block scrambler with periodic lane marker group insertion.
// Assumes a transcoder feeding one block per valid/ready beat and a
// pre-FEC distributor that takes one 257-bit word whenever out_valid is high.
//
// Behaviour
// - every transcoded 257-bit block is scrambled by a 58-bit self-synchronizing scrambler.
// - 8-lane group holds eight markers, 65-bit pad, 3-bit status: four blocks.
// - each group starts a pair of FEC messages and interrupts data in progress.
// - pad comes from free-running PRBS9 x^9+x^5+1 with nonzero seed.
// - group inserted after scrambling; never scrambled nor transcoded.
// - marker octets ordered cm0-2, up0, cm3-5, up1, um0-2, up2, um3-5.
// - common octets equal on every lane; unique octets chosen by lane number.
// - status field holds degrade flag in bit 2, bits 1 and 0 zero.
// - 10-bit interleave at 80k+20j, lane pair swapped on odd k.
// - 65 pad bits occupy group bits 960..1024, earliest bit at 960.
// - status field occupies group bits 1025..1027, completing 1028 bits.
// - group inserted once every 81920 blocks of the output stream.
// - marker super-block: group in bits 0..1027, then 36 scrambled blocks.
// - plain super-block holds forty consecutive scrambled blocks.
// - input FIFO absorbs blocks arriving during each group; in_ready is low only in reset or when it fills.
// - marker octets follow the lane table, each sent LSB first.
// - bit 0 of each 257-bit block is the first bit transmitted.
`timescale 1ns/1ns
`default_nettype none
`include "tsmi_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module tsmi_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)
(
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] s_data,
  input  wire logic             s_valid,
  output logic                  s_ready,
  output logic [WIDTH-1:0]      m_data,
  output logic                  m_valid,
  input  wire logic             m_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign push    = s_valid && s_ready;
  assign pop     = m_valid && m_ready;
  assign m_valid = (count != '0);
  assign m_data  = mem[rd_ptr];

  always_comb
  begin
    next_count = count;
    if (push && !pop)
      next_count = count + 1'b1;
    else if (pop && !push)
      next_count = count - 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count   <= '0;
      s_ready <= 1'b0;
    end
    else
    begin
      count   <= next_count;
      s_ready <= (next_count < (AW+1)'(DEPTH));
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
    end
  end

  // Storage needs no reset; only count defines validity
  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem[wr_ptr] <= s_data;
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module tsmi_top
  import tsmi_pkg::*;
#(
  parameter int PERIOD_WORDS = `TSMI_PERIOD,
  parameter int FIFO_DEPTH   = `TSMI_FIFO_DEPTH
)
(
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  input  wire tsmi_word_type in_block,
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic          fec_degrade_flag,
  output tsmi_word_type      out_data,
  output logic               out_valid,
  output logic               out_marker,
  output logic               out_sb_start
);
  localparam int PW = $clog2(PERIOD_WORDS);
  localparam int SW = $clog2(`TSMI_SB_WORDS);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic tsmi_am_type lane_marker(input int lane);
    logic [71:0] u;
    case (lane)
      0:       u = `TSMI_LANE0;
      1:       u = `TSMI_LANE1;
      2:       u = `TSMI_LANE2;
      3:       u = `TSMI_LANE3;
      4:       u = `TSMI_LANE4;
      5:       u = `TSMI_LANE5;
      6:       u = `TSMI_LANE6;
      default: u = `TSMI_LANE7;
    endcase
    // Octet n sits at bits 8n+7:8n, so each goes out LSB first
    return {u[71:16], u[15:8], `TSMI_CM_HI, u[7:0], `TSMI_CM_LO};
  endfunction

  function automatic tsmi_grp_type build_group(input logic [`TSMI_PAD_BITS-1:0] pad,
                                               input logic                      degrade);
    tsmi_grp_type g;
    tsmi_am_type  am_lo;
    tsmi_am_type  am_hi;
    g = '0;
    for (int k = 0; k < `TSMI_SLICES; k++)
    begin
      for (int j = 0; j < `TSMI_LANES/2; j++)
      begin
        am_lo = lane_marker(2*j);
        am_hi = lane_marker(2*j+1);
        if (k % 2 == 0)
        begin
          g[`TSMI_SLICE*(`TSMI_LANES*k+2*j) +: `TSMI_SLICE]   = am_lo[`TSMI_SLICE*k +: `TSMI_SLICE];
          g[`TSMI_SLICE*(`TSMI_LANES*k+2*j+1) +: `TSMI_SLICE] = am_hi[`TSMI_SLICE*k +: `TSMI_SLICE];
        end
        else
        begin
          g[`TSMI_SLICE*(`TSMI_LANES*k+2*j) +: `TSMI_SLICE]   = am_hi[`TSMI_SLICE*k +: `TSMI_SLICE];
          g[`TSMI_SLICE*(`TSMI_LANES*k+2*j+1) +: `TSMI_SLICE] = am_lo[`TSMI_SLICE*k +: `TSMI_SLICE];
        end
      end
    end
    g[`TSMI_PAD_LO +: `TSMI_PAD_BITS] = pad;
    g[`TSMI_SF_LO +: 3] = {degrade, 2'b00};
    return g;
  endfunction

  // Returns {next state, 65 pad bits}; bit 0 is the earliest output
  function automatic logic [`TSMI_PAD_BITS+8:0] prbs_run(input logic [8:0] st);
    logic [`TSMI_PAD_BITS-1:0] bits;
    logic                      b;
    bits = '0;
    for (int i = 0; i < `TSMI_PAD_BITS; i++)
    begin
      b       = st[`TSMI_PRBS_TAP_A] ^ st[`TSMI_PRBS_TAP_B];
      bits[i] = b;
      st      = {st[7:0], b};
    end
    return {st, bits};
  endfunction

  // Returns {next state, scrambled word}; bit 0 is scrambled first
  function automatic logic [`TSMI_SCR_BITS+`TSMI_WORD_BITS-1:0] scramble(
    input tsmi_word_type            din,
    input logic [`TSMI_SCR_BITS-1:0] st);
    tsmi_word_type dout;
    logic          o;
    dout = '0;
    for (int i = 0; i < `TSMI_WORD_BITS; i++)
    begin
      o       = din[i] ^ st[`TSMI_SCR_TAP_A] ^ st[`TSMI_SCR_TAP_B];
      dout[i] = o;
      st      = {st[`TSMI_SCR_BITS-2:0], o};
    end
    return {st, dout};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input buffering

  tsmi_word_type f_data;
  logic          f_valid;
  logic          f_ready;

  tsmi_fifo
  #(
    .WIDTH (`TSMI_WORD_BITS),
    .DEPTH (FIFO_DEPTH)
  )
  u_fifo
  (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .s_data  (in_block),
    .s_valid (in_valid),
    .s_ready (in_ready),
    .m_data  (f_data),
    .m_valid (f_valid),
    .m_ready (f_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing

  logic [PW-1:0]             wcnt;
  logic [SW-1:0]             spos;
  logic [SW-1:0]             out_pos;
  logic [8:0]                prbs;
  logic [`TSMI_SCR_BITS-1:0] scr;
  logic                      stat;
  tsmi_phase_type            phase;
  logic                      emit;
  tsmi_grp_type              grp;
  tsmi_word_type             mk_word;
  logic [`TSMI_PAD_BITS+8:0] prbs_res;
  logic [`TSMI_SCR_BITS+`TSMI_WORD_BITS-1:0] scr_res;
  tsmi_word_type             raw_q;

  assign phase    = (wcnt < PW'(`TSMI_AM_WORDS)) ? TSMI_PH_MARK : TSMI_PH_DATA;
  // Drain halts through the group so the FIFO absorbs the gap
  assign f_ready  = (phase == TSMI_PH_DATA);
  assign emit     = (phase == TSMI_PH_MARK) || f_valid;
  assign prbs_res = prbs_run(prbs);
  assign grp      = build_group(prbs_res[`TSMI_PAD_BITS-1:0], stat);
  assign mk_word  = grp[`TSMI_WORD_BITS*int'(wcnt[1:0]) +: `TSMI_WORD_BITS];
  assign scr_res  = scramble(f_data, scr);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wcnt <= '0;
      spos <= '0;
    end
    else if (emit)
    begin
      wcnt <= (wcnt == PW'(PERIOD_WORDS-1)) ? '0 : wcnt + 1'b1;
      spos <= (spos == SW'(`TSMI_SB_WORDS-1)) ? '0 : spos + 1'b1;
    end
  end

  // Pad keeps running from group to group rather than restarting
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      prbs <= `TSMI_PRBS_SEED;
    else if (emit && wcnt == PW'(`TSMI_AM_WORDS-1))
      prbs <= prbs_res[`TSMI_PAD_BITS+8:`TSMI_PAD_BITS];
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      stat <= 1'b0;
    else if (emit && wcnt == '0)
      stat <= fec_degrade_flag;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      scr <= `TSMI_SCR_SEED;
    else if (f_valid && f_ready)
      scr <= scr_res[`TSMI_SCR_BITS+`TSMI_WORD_BITS-1:`TSMI_WORD_BITS];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stage

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_data     <= '0;
      out_valid    <= 1'b0;
      out_marker   <= 1'b0;
      out_sb_start <= 1'b0;
      out_pos      <= '0;
      raw_q        <= '0;
    end
    else
    begin
      out_valid    <= emit;
      out_marker   <= (phase == TSMI_PH_MARK);
      out_sb_start <= emit && (spos == '0);
      out_pos      <= spos;
      raw_q        <= f_data;
      if (phase == TSMI_PH_MARK)
        out_data <= mk_word;
      else
        out_data <= scr_res[`TSMI_WORD_BITS-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  tsmi_am_type am0;
  tsmi_am_type am1;
  assign am0 = lane_marker(0);
  assign am1 = lane_marker(1);

  property p_group_len;
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(out_marker) |-> out_marker [*4] ##1 !out_marker;
  endproperty
  a_group_len: assert property (p_group_len) else $error("marker group not four words");

  property p_group_start;
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(out_marker) |-> out_sb_start && out_valid;
  endproperty
  a_group_start: assert property (p_group_start) else $error("group not at super-block start");

  property p_interleave;
    @(posedge ref_clk) disable iff (!rst_n)
    out_marker && out_sb_start |-> out_data[19:0] == {am1[9:0], am0[9:0]};
  endproperty
  a_interleave: assert property (p_interleave) else $error("first slices wrong");

  property p_common;
    @(posedge ref_clk) disable iff (!rst_n)
    out_marker && out_sb_start |-> out_data[7:0] == am1[7:0];
  endproperty
  a_common: assert property (p_common) else $error("common octet differs");

  property p_status;
    @(posedge ref_clk) disable iff (!rst_n)
    out_marker && out_pos == SW'(3) |-> out_data[256:254] == {stat, 2'b00};
  endproperty
  a_status: assert property (p_status) else $error("status field wrong");

  property p_prbs_live;
    @(posedge ref_clk) disable iff (!rst_n)
    prbs != '0;
  endproperty
  a_prbs_live: assert property (p_prbs_live) else $error("prbs state zero");

  property p_scramble;
    @(posedge ref_clk) disable iff (!rst_n)
    out_valid && !out_marker |-> out_data[100] == (raw_q[100] ^ out_data[61] ^ out_data[42]);
  endproperty
  a_scramble: assert property (p_scramble) else $error("scrambler taps wrong");

  property p_period;
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(out_marker) |-> wcnt == PW'(1) && $past(wcnt) == '0;
  endproperty
  a_period: assert property (p_period) else $error("group off its period");

  property p_hold;
    @(posedge ref_clk) disable iff (!rst_n)
    phase == TSMI_PH_MARK |-> !f_ready ##1 out_marker;
  endproperty
  a_hold: assert property (p_hold) else $error("data drained during group");

  c_group: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(out_marker));
  c_full:  cover property (@(posedge ref_clk) disable iff (!rst_n) !in_ready ##1 in_ready);
  c_plain: cover property (@(posedge ref_clk) disable iff (!rst_n) out_sb_start && !out_marker);
endmodule
`default_nettype wire

// ---- hw/tsmi_regs.svh ----
// Constants for the transmit scrambler and marker inserter.
// Assumes inclusion by bare name from the package and design files.
`ifndef TSMI_REGS_SVH
`define TSMI_REGS_SVH

`define TSMI_WORD_BITS   257
`define TSMI_GRP_BITS    1028
`define TSMI_AM_BITS     120
`define TSMI_AM_WORDS    4
`define TSMI_SB_WORDS    40
`define TSMI_PERIOD      81920
`define TSMI_LANES       8
`define TSMI_SLICE       10
`define TSMI_SLICES      12
`define TSMI_PAD_LO      960
`define TSMI_PAD_BITS    65
`define TSMI_SF_LO       1025
`define TSMI_SCR_BITS    58
`define TSMI_SCR_TAP_A   38
`define TSMI_SCR_TAP_B   57
`define TSMI_SCR_SEED    58'h3FFFFFFFFFFFFFF
`define TSMI_PRBS_SEED   9'h1FF
`define TSMI_PRBS_TAP_A  8
`define TSMI_PRBS_TAP_B  4
`define TSMI_FIFO_DEPTH  8
`define TSMI_CM_LO       24'h264A9A
`define TSMI_CM_HI       24'hD9B565
// Per lane: {um5,um4,um3,up2,um2,um1,um0,up1,up0}
`define TSMI_LANE0       72'h733F4C298CC0B3D605
`define TSMI_LANE1       72'h8121A5987EDE5A6704
`define TSMI_LANE2       72'hA90CC10156F33EFE46
`define TSMI_LANE3       72'h2F7F797BD08086845A
`define TSMI_LANE4       72'h0DAED5E6F2512A19E1
`define TSMI_LANE5       72'h2EB0EDB1D14F124EF2
`define TSMI_LANE6       72'h5E63BD11A19C42EE3D
`define TSMI_LANE7       72'hA48929CD5B76D63222

`endif

// ---- hw/tsmi_pkg.sv ----
// Types shared by the transmit scrambler and marker inserter.
// Assumes tsmi_regs.svh is on the include path.
`include "tsmi_regs.svh"

package tsmi_pkg;
  typedef logic [`TSMI_WORD_BITS-1:0] tsmi_word_type;
  typedef logic [`TSMI_GRP_BITS-1:0]  tsmi_grp_type;
  typedef logic [`TSMI_AM_BITS-1:0]   tsmi_am_type;
  typedef enum logic {TSMI_PH_MARK, TSMI_PH_DATA} tsmi_phase_type;
endpackage

// ---- tb/tsmi_src.sv ----
// Upstream block source in place of the transcoder.
// Assumes the bench raises target to ask for more blocks.
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module tsmi_src
  import tsmi_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] target,
  input  wire logic        stall,
  input  wire logic        in_ready,
  output var tsmi_word_type in_block,
  output logic             in_valid,
  output logic             done
);
  logic [15:0] sent;
  logic [15:0] lim;
  logic        stl;
  logic        took;
  logic [1:0]  gap;
  logic        nv;

  initial
  begin
    in_block = '0;
    in_valid = 1'b0;
    done = 1'b1;
    sent = '0;
    gap = '0;
  end

  always @(posedge ref_clk)
  begin
    took <= rst_n && in_valid && in_ready;
    lim <= target;
    stl <= stall;
  end

  // Offer held until taken; upstream waits while in_ready is low, and every fourth cycle when stall is set
  always @(negedge ref_clk)
  begin
    nv = in_valid && !took;
    gap = gap + 2'h1;
    if (!rst_n)
    begin
      sent = '0;
      nv = 1'b0;
    end
    else
    begin
      if (took)
        sent = sent + 16'h1;
      if (!nv && sent < lim && !(stl && gap == 2'h0))
      begin
        nv = 1'b1;
        in_block = tsmi_word_type'({9{(32'h9E3779B9 * {16'h0, sent}) ^ 32'hC3A50F1E}});
      end
      else if (!nv)
        in_block = ~in_block;
    end
    in_valid = nv;
    done = (sent == lim) && !nv;
  end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the scrambler and marker inserter.
// Assumes the short insertion period of 80 words.
`timescale 1ns/1ns
`default_nettype none
`include "tsmi_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module tb_top
  import tsmi_pkg::*;
;
  localparam int P = 80;
  localparam logic [71:0] LANE [8] = '{`TSMI_LANE0, `TSMI_LANE1, `TSMI_LANE2, `TSMI_LANE3,
                                       `TSMI_LANE4, `TSMI_LANE5, `TSMI_LANE6, `TSMI_LANE7};
  logic          ref_clk, rst_n, in_valid, in_ready, flag, stall, done;
  logic          out_valid, out_marker, out_sb_start;
  tsmi_word_type in_block, out_data;
  tsmi_word_type q [$];
  tsmi_grp_type  grp;
  logic [15:0]   target;
  logic [57:0]   scr;
  logic [8:0]    prbs;
  int            n_mismatch, tests_run, widx;

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  tsmi_top #(.PERIOD_WORDS(P), .FIFO_DEPTH(8)) u_tsmi_top (
    .ref_clk(ref_clk), .rst_n(rst_n), .in_block(in_block), .in_valid(in_valid),
    .in_ready(in_ready), .fec_degrade_flag(flag), .out_data(out_data),
    .out_valid(out_valid), .out_marker(out_marker), .out_sb_start(out_sb_start));

  tsmi_src u_tsmi_src (
    .ref_clk(ref_clk), .rst_n(rst_n), .target(target), .stall(stall),
    .in_ready(in_ready), .in_block(in_block), .in_valid(in_valid), .done(done));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input tsmi_word_type seen, input tsmi_word_type exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  function automatic tsmi_word_type scram(input tsmi_word_type d);
    tsmi_word_type o;
    for (int i = 0; i < `TSMI_WORD_BITS; i++)
    begin
      o[i] = d[i] ^ scr[38] ^ scr[57];
      scr = {scr[56:0], o[i]};
    end
    return o;
  endfunction

  function automatic tsmi_grp_type mk_grp(input logic f);
    tsmi_grp_type g;
    tsmi_am_type  am [8];
    for (int x = 0; x < 8; x++)
      am[x] = {LANE[x][71:8], `TSMI_CM_HI, LANE[x][7:0], `TSMI_CM_LO};
    for (int k = 0; k < 12; k++)
      for (int j = 0; j < 4; j++)
      begin
        g[80*k+20*j +: 10] = am[2*j+k%2][10*k +: 10];
        g[80*k+20*j+10 +: 10] = am[2*j+1-k%2][10*k +: 10];
      end
    for (int b = 0; b < 65; b++)
    begin
      g[960+b] = prbs[8] ^ prbs[4];
      prbs = {prbs[7:0], g[960+b]};
    end
    g[1027:1025] = {f, 2'b00};
    return g;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Output monitor; model state restarts with every reset
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      q.delete();
      widx = 0;
      scr = '1;
      prbs = 9'h1FF;
    end
    else
    begin
      if (in_valid && in_ready)
        q.push_back(in_block);
      if (out_valid === 1'b1)
      begin
        if (widx == 0)
          grp = mk_grp(flag);
        check(out_marker, widx < 4);
        check(out_sb_start, widx % 40 == 0);
        if (widx < 4)
          check(out_data, grp[257*widx +: 257]);
        else if (q.size() == 0)
          check(out_valid, 1'b0);
        else
          check(out_data, scram(q.pop_front()));
        widx = (widx + 1) % P;
      end
      else
        check(widx == 0 || widx > 3, 1'b1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Negative v waits for the stream to drain
  task automatic wait_for(input int v);
    int t;
    t = 0;
    repeat (2) @(negedge ref_clk);
    while ((v < 0 ? !(done && q.size() == 0) : widx != v) && t < 3000)
    begin
      @(negedge ref_clk);
      t++;
    end
    if (t == 3000)
    begin
      n_mismatch++;
      wrap_up();
    end
  endtask

  task automatic sc_reset();
    rst_n = 1'b0;
    target = '0;
    repeat (16) @(negedge ref_clk);
    check(out_valid, 1'b0);
    check(in_ready, 1'b0);
    check(out_data, '0);
    rst_n = 1'b1;
  endtask

  // Back to back over several periods
  task automatic sc_plain();
    stall = 1'b0;
    target = target + 16'd200;
    wait_for(-1);
  endtask

  // Degrade flag raised mid data, source with gaps
  task automatic sc_degrade();
    stall = 1'b1;
    target = target + 16'd200;
    wait_for(20);
    flag = 1'b1;
    wait_for(-1);
  endtask

  // Reset in mid stream must restart scrambler, pad and period
  task automatic sc_midreset();
    stall = 1'b0;
    target = target + 16'd60;
    wait_for(30);
    sc_reset();
    target = 16'd60;
    wait_for(-1);
  endtask

  initial
  begin
    rst_n = 1'b0;
    flag = 1'b0;
    stall = 1'b0;
    target = '0;
    n_mismatch = 0;
    tests_run = 0;
    widx = 0;
    sc_reset();
    sc_plain();
    sc_degrade();
    sc_midreset();
    wrap_up();
  end
endmodule
`default_nettype wire
